/* File: rtl/iepw_top.sv */
// Interrupt enable, timer-gate priority and low-power wake block with AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
module iepw_top #(
  parameter bit HAS_SERIAL2 = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [iepw_pkg::IEPW_NSRC-1:0] SRC_FLAG,
  input wire logic SLEEPING,
  input wire logic WAKE_PIN_LOW,
  output logic WAKE_SINK_ON,
  output logic WAKE_CORE,
  output logic [iepw_pkg::IEPW_NSRC-1:0] IRQ_REQ,
  output logic [2:0] TGATE_PRIORITY,
  output logic IRQ
);
  import iepw_pkg::*;

  // =========================================
  // Registers
  logic tgate_en_reg, coll2_en_reg, evt2_en_reg, hlvd_en_reg;
  logic asy2_en_reg, asy1_en_reg, wake_en_reg;
  logic [2:0] pri_reg;
  logic wen_reg, sink_reg, wake_flag_reg;
  logic [IEPW_NSRC-1:0] stat_reg, mask_reg, en_vec;
  logic pin_low_s;
  logic aw_got_reg, w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, wr_hit, wake_evt;

  // Pin level crosses into the clock domain
  iepw_sync #(.W(1)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .d(WAKE_PIN_LOW),
    .q(pin_low_s)
  );

  // =========================================
  // AXI write channel: address and data accepted in either order
  assign S_AXI_AWREADY = !aw_got_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_got_reg && !S_AXI_BVALID;
  assign wr_fire = aw_got_reg && w_got_reg && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  // Known word-aligned offsets
  function automatic logic addr_hit(input logic [7:0] a);
    unique case ({a[7:2], 2'b00})
      IEPW_OFS_EN2, IEPW_OFS_EN3, IEPW_OFS_EN4, IEPW_OFS_EN5, IEPW_OFS_PRI9,
      IEPW_OFS_WCTL, IEPW_OFS_FLAG5, IEPW_OFS_STAT, IEPW_OFS_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // Write hits a lane: low byte or second byte
  function automatic logic wr_to(input logic [7:0] ofs, input int bitpos);
    wr_to = wr_fire && ({awaddr_reg[7:2], 2'b00} == ofs) && wstrb_reg[bitpos / 8];
  endfunction

  assign wr_hit = addr_hit(awaddr_reg);

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= IEPW_RESP_OK;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_hit ? IEPW_RESP_OK : IEPW_RESP_ERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // =========================================
  // Enable and priority registers; absent bits always load zero
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tgate_en_reg <= 1'b0;
      coll2_en_reg <= 1'b0;
      evt2_en_reg <= 1'b0;
      hlvd_en_reg <= 1'b0;
      asy2_en_reg <= 1'b0;
      asy1_en_reg <= 1'b0;
      wake_en_reg <= 1'b0;
      pri_reg <= IEPW_PRI_RST;
    end else begin
      if (wr_to(IEPW_OFS_EN2, IEPW_BIT_TGATE))
        tgate_en_reg <= wdata_reg[IEPW_BIT_TGATE];
      if (wr_to(IEPW_OFS_EN3, IEPW_BIT_COLL2)) begin
        coll2_en_reg <= HAS_SERIAL2 & wdata_reg[IEPW_BIT_COLL2];
        evt2_en_reg <= HAS_SERIAL2 & wdata_reg[IEPW_BIT_EVT2];
      end
      if (wr_to(IEPW_OFS_EN4, IEPW_BIT_HLVD))
        hlvd_en_reg <= wdata_reg[IEPW_BIT_HLVD];
      if (wr_to(IEPW_OFS_EN4, IEPW_BIT_ASY1)) begin
        asy2_en_reg <= HAS_SERIAL2 & wdata_reg[IEPW_BIT_ASY2];
        asy1_en_reg <= wdata_reg[IEPW_BIT_ASY1];
      end
      if (wr_to(IEPW_OFS_EN5, IEPW_BIT_WAKE))
        wake_en_reg <= wdata_reg[IEPW_BIT_WAKE];
      if (wr_to(IEPW_OFS_PRI9, IEPW_PRI_LSB))
        pri_reg <= wdata_reg[IEPW_PRI_LSB +: IEPW_PRI_W];
    end
  end

  // =========================================
  // Wake detector control, sink and wake flag
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wen_reg <= 1'b0;
      sink_reg <= 1'b0;
    end else if (wr_to(IEPW_OFS_WCTL, IEPW_BIT_WEN)) begin
      wen_reg <= wdata_reg[IEPW_BIT_WEN];
      sink_reg <= wdata_reg[IEPW_BIT_SINK];
    end
  end

  // Sink on only with both bits; pin charged by software beforehand
  assign WAKE_SINK_ON = wen_reg && sink_reg;
  // Falling below threshold while asleep wakes the core
  assign wake_evt = WAKE_SINK_ON && SLEEPING && pin_low_s;
  assign WAKE_CORE = wake_evt;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wake_flag_reg <= 1'b0;
    end else if (wake_evt) begin
      wake_flag_reg <= 1'b1;
    end else if (wr_to(IEPW_OFS_FLAG5, IEPW_BIT_WAKE) && wdata_reg[IEPW_BIT_WAKE]) begin
      wake_flag_reg <= 1'b0;
    end
  end

  // =========================================
  // Request gating
  assign en_vec = {wake_en_reg, asy1_en_reg, asy2_en_reg, hlvd_en_reg,
                   evt2_en_reg, coll2_en_reg, tgate_en_reg};
  always_comb begin
    IRQ_REQ = SRC_FLAG & en_vec;
    IRQ_REQ[IEPW_SRC_WAKE] = (SRC_FLAG[IEPW_SRC_WAKE] | wake_flag_reg) & wake_en_reg;
    IRQ_REQ[IEPW_SRC_TGATE] = SRC_FLAG[IEPW_SRC_TGATE] & tgate_en_reg
                              & (pri_reg != 3'h0);
  end
  assign TGATE_PRIORITY = pri_reg;

  // =========================================
  // Sticky status of gated requests, mask to one interrupt line
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (wr_to(IEPW_OFS_STAT, 0))
        stat_reg <= (stat_reg & ~wdata_reg[IEPW_NSRC-1:0]) | IRQ_REQ;
      else
        stat_reg <= stat_reg | IRQ_REQ;
      if (wr_to(IEPW_OFS_MASK, 0))
        mask_reg <= wdata_reg[IEPW_NSRC-1:0];
    end
  end
  assign IRQ = |(stat_reg & mask_reg);

  // =========================================
  // AXI read channel, one cycle latency
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0;
    unique case ({a[7:2], 2'b00})
      IEPW_OFS_EN2: rd_word[IEPW_BIT_TGATE] = tgate_en_reg;
      IEPW_OFS_EN3: begin
        rd_word[IEPW_BIT_COLL2] = coll2_en_reg;
        rd_word[IEPW_BIT_EVT2] = evt2_en_reg;
      end
      IEPW_OFS_EN4: begin
        rd_word[IEPW_BIT_HLVD] = hlvd_en_reg;
        rd_word[IEPW_BIT_ASY2] = asy2_en_reg;
        rd_word[IEPW_BIT_ASY1] = asy1_en_reg;
      end
      IEPW_OFS_EN5: rd_word[IEPW_BIT_WAKE] = wake_en_reg;
      IEPW_OFS_PRI9: rd_word[IEPW_PRI_LSB +: IEPW_PRI_W] = pri_reg;
      IEPW_OFS_WCTL: begin
        rd_word[IEPW_BIT_WEN] = wen_reg;
        rd_word[IEPW_BIT_SINK] = sink_reg;
      end
      IEPW_OFS_FLAG5: rd_word[IEPW_BIT_WAKE] = wake_flag_reg;
      IEPW_OFS_STAT: rd_word[IEPW_NSRC-1:0] = stat_reg;
      IEPW_OFS_MASK: rd_word[IEPW_NSRC-1:0] = mask_reg;
      default: rd_word = 32'h0;
    endcase
  endfunction

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= IEPW_RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word(S_AXI_ARADDR);
      S_AXI_RRESP <= addr_hit(S_AXI_ARADDR) ? IEPW_RESP_OK : IEPW_RESP_ERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // =========================================
  // Checks
  sequence s_armed_low;
    WAKE_SINK_ON && SLEEPING && pin_low_s;
  endsequence

  AST_WAKE_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_armed_low |=> wake_flag_reg)
    else $error("wake flag not set after wake");
  // Pin level must have come through both sync stages
  AST_WAKE_CORE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    WAKE_CORE |-> (SLEEPING && $past(WAKE_PIN_LOW, 2) && wen_reg && sink_reg))
    else $error("wake without armed low pin");
  // Control write reaches the sink output one cycle later
  AST_SINK: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_fire && {awaddr_reg[7:2], 2'b00} == IEPW_OFS_WCTL && wstrb_reg[0])
    |=> WAKE_SINK_ON == ($past(wdata_reg[IEPW_BIT_WEN]) && $past(wdata_reg[IEPW_BIT_SINK])))
    else $error("sink state wrong");
  AST_GATE_EN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !asy1_en_reg |-> !IRQ_REQ[IEPW_SRC_ASY1])
    else $error("disabled source passed");
  AST_PRI_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (pri_reg == 3'h0) |-> !IRQ_REQ[IEPW_SRC_TGATE])
    else $error("zero priority passed request");
  AST_PRI_RST: assert property (@(posedge SYS_CLK)
    $rose(RESETN) |-> pri_reg == IEPW_PRI_RST)
    else $error("priority reset value wrong");
  AST_NO_SER2: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !HAS_SERIAL2 |-> !(coll2_en_reg || evt2_en_reg || asy2_en_reg))
    else $error("absent serial enable set");
  // Read data carries the enable as it stood when the address was taken
  AST_RD_EN5: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == IEPW_OFS_EN5)
    |=> S_AXI_RDATA == {31'h0, $past(wake_en_reg)})
    else $error("enable bank 5 readback wrong");
  AST_TG_WR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (wr_fire && {awaddr_reg[7:2], 2'b00} == IEPW_OFS_EN2 && wstrb_reg[0])
    |=> tgate_en_reg == $past(wdata_reg[IEPW_BIT_TGATE]))
    else $error("timer gate enable write lost");
endmodule
`default_nettype wire

/* File: shared/iepw_pkg.sv */
// Package: register map, field positions and reset values of the enable/priority/wake block
package iepw_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] IEPW_OFS_EN2 = 8'h00;
  localparam logic [7:0] IEPW_OFS_EN3 = 8'h04;
  localparam logic [7:0] IEPW_OFS_EN4 = 8'h08;
  localparam logic [7:0] IEPW_OFS_EN5 = 8'h0c;
  localparam logic [7:0] IEPW_OFS_PRI9 = 8'h10;
  localparam logic [7:0] IEPW_OFS_WCTL = 8'h14;
  localparam logic [7:0] IEPW_OFS_FLAG5 = 8'h18;
  localparam logic [7:0] IEPW_OFS_STAT = 8'h1c;
  localparam logic [7:0] IEPW_OFS_MASK = 8'h20;
  // Field positions
  localparam int IEPW_BIT_TGATE = 5;
  localparam int IEPW_BIT_COLL2 = 2;
  localparam int IEPW_BIT_EVT2 = 1;
  localparam int IEPW_BIT_HLVD = 8;
  localparam int IEPW_BIT_ASY2 = 2;
  localparam int IEPW_BIT_ASY1 = 1;
  localparam int IEPW_BIT_WAKE = 0;
  localparam int IEPW_PRI_LSB = 4;
  localparam int IEPW_PRI_W = 3;
  localparam int IEPW_BIT_WEN = 0;
  localparam int IEPW_BIT_SINK = 1;
  // Reset value and source count
  localparam logic [2:0] IEPW_PRI_RST = 3'h4;
  localparam int IEPW_NSRC = 7;
  // Source order in request/status vectors
  localparam int IEPW_SRC_TGATE = 0;
  localparam int IEPW_SRC_COLL2 = 1;
  localparam int IEPW_SRC_EVT2 = 2;
  localparam int IEPW_SRC_HLVD = 3;
  localparam int IEPW_SRC_ASY2 = 4;
  localparam int IEPW_SRC_ASY1 = 5;
  localparam int IEPW_SRC_WAKE = 6;
  // AXI responses
  localparam logic [1:0] IEPW_RESP_OK = 2'h0;
  localparam logic [1:0] IEPW_RESP_ERR = 2'h2;
endpackage

/* File: rtl/iepw_sync.sv */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
`default_nettype none
module iepw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // A zero-wide chain has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("sync width must be at least one");
  end
  // =========================================
  // Sync chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: sim/iepw_far_model.sv */
// Far-side model: wake pin capacitor and processor core sleep state
`timescale 1ns/1ns
`default_nettype none
module iepw_far_model #(
  parameter int DISCH = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic charge,
  input wire logic sleep_go,
  input wire logic sink_on,
  input wire logic wake,
  output logic pin_low,
  output var logic sleeping
);
  int level;
  // ==========================================
  // Capacitor charge as a count, drained by the sink
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      level <= 0;
    else if (charge)
      level <= DISCH;
    else if (sink_on && level > 0)
      level <= level - 1;
  end
  // Empty capacitor sits below the input-low threshold
  assign pin_low = (level == 0);
  // ==========================================
  // Core sleeps on command, resumes only on a wake request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sleeping <= 1'b0;
    else if (sleep_go)
      sleeping <= 1'b1;
    else if (wake)
      sleeping <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Testbench: register map, request gating, status interrupt and low-power wake
`timescale 1ns/1ns
`default_nettype none
module tb;
  import iepw_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [6:0] src = 7'h00;
  logic charge = 1'b0;
  logic sleep_go = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sleeping, pin_low, sink_on, wake, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [6:0] irq_req;
  logic [6:0] irq_req_lite;
  logic [2:0] tprio;
  logic [7:0] ofs [5] = '{IEPW_OFS_EN2, IEPW_OFS_EN3, IEPW_OFS_EN4, IEPW_OFS_EN5, IEPW_OFS_PRI9};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h40};
  logic [31:0] ones [5] = '{32'h20, 32'h6, 32'h106, 32'h1, 32'h70};
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  iepw_top u_iepw_top (.SYS_CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SRC_FLAG(src), .SLEEPING(sleeping), .WAKE_PIN_LOW(pin_low),
    .WAKE_SINK_ON(sink_on), .WAKE_CORE(wake), .IRQ_REQ(irq_req),
    .TGATE_PRIORITY(tprio), .IRQ(irq));
  iepw_far_model u_iepw_far_model (.clk(clk), .rst_n(rstn), .charge(charge),
    .sleep_go(sleep_go), .sink_on(sink_on), .wake(wake), .pin_low(pin_low),
    .sleeping(sleeping));
  // Variant without the second serial port, sharing bus and far side
  iepw_top #(.HAS_SERIAL2(1'b0)) u_iepw_top_lite (.SYS_CLK(clk), .RESETN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
    .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(),
    .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(), .S_AXI_RREADY(rready),
    .SRC_FLAG(src), .SLEEPING(sleeping), .WAKE_PIN_LOW(pin_low), .WAKE_SINK_ON(),
    .WAKE_CORE(), .IRQ_REQ(irq_req_lite), .TGATE_PRIORITY(), .IRQ());
  // ==========================================
  // Comparison and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Let edge updates and the design's registered outputs land
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // ==========================================
  // Bus master; handshakes sampled at the negedge before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      if (awvalid && awready) aw = 1'b0;
      if (wvalid && wready) w = 1'b0;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ar, done;
    ar = 1'b1;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      if (arvalid && arready) ar = 1'b0;
      done = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk);
      if (!ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // ==========================================
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(ofs[i], rv[i]);
    for (int i = 0; i < 5; i++) wr(ofs[i], 32'hffffffff);
    for (int i = 0; i < 5; i++) rchk(ofs[i], ones[i]);
    chk({29'h0, tprio}, 32'h7);
    @(posedge clk);
    src <= 7'h3f;
    settle();
    chk({25'h0, irq_req}, 32'h3f);
    chk({25'h0, irq_req_lite}, 32'h29);
    chk({31'h0, irq}, 32'h0);
    rchk(IEPW_OFS_STAT, 32'h3f);
    src <= 7'h00;
    wr(IEPW_OFS_MASK, 32'h20);
    chk({30'h0, r}, {30'h0, IEPW_RESP_OK});
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(IEPW_OFS_STAT, 32'h20);
    settle();
    chk({31'h0, irq}, 32'h0);
    rchk(IEPW_OFS_STAT, 32'h1f);
    chk({30'h0, r}, {30'h0, IEPW_RESP_OK});
    // Zero priority silences the timer gate even when enabled
    wr(IEPW_OFS_PRI9, 32'h0);
    src <= 7'h01;
    settle();
    chk({29'h0, tprio}, 32'h0);
    chk({25'h0, irq_req}, 32'h0);
    for (int i = 0; i < 4; i++) wr(ofs[i], 32'h0);
    for (int i = 0; i < 4; i++) rchk(ofs[i], 32'h0);
    src <= 7'h3f;
    settle();
    chk({25'h0, irq_req}, 32'h0);
    @(posedge clk);
    src <= 7'h00;
    // Unmapped place answers with an error and no data
    rd(8'h24, d);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, IEPW_RESP_ERR});
    wr(8'h24, 32'h1);
    chk({30'h0, r}, {30'h0, IEPW_RESP_ERR});
    // Low-power wake: charge, release, arm, sleep
    wr(IEPW_OFS_EN5, 32'h1);
    charge <= 1'b1;
    settle();
    @(posedge clk);
    charge <= 1'b0;
    wr(IEPW_OFS_WCTL, 32'h3);
    chk({31'h0, sink_on}, 32'h1);
    sleep_go <= 1'b1;
    @(posedge clk);
    sleep_go <= 1'b0;
    settle();
    chk({31'h0, sleeping}, 32'h1);
    chk({31'h0, wake}, 32'h0);
    for (int i = 0; i < 100 && sleeping; i++) @(negedge clk);
    chk({31'h0, sleeping}, 32'h0);
    rchk(IEPW_OFS_FLAG5, 32'h1);
    wr(IEPW_OFS_WCTL, 32'h0);
    chk({31'h0, sink_on}, 32'h0);
    wr(IEPW_OFS_FLAG5, 32'h1);
    rchk(IEPW_OFS_FLAG5, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
